// ===== design/inhibit_mon_pkg.sv
// Constants, types and register map of the dual-channel torque inhibit monitor
//
// Overview of operation
// - Both inputs low: block start, status on unless fault latched
// - Both inputs high: allow software run unless fault latched, status off
// - Inputs disagree: block start, status off
// - Disagreement up to 1.6 s raises no fault
// - Disagreement beyond 3.0 s always raises fault
// - Fault latches by itself, no input change needed
// - Fault holds start blocked until power cycle
// - Low test pulses under 2 ms are ignored
// - Low level acted on after about 6 ms
// - Trip when inhibited while running or starting
// - Internal circuit fault also raises the trip
// - History entry only at start or running
// - Unconnected inputs trip on first start attempt
// - Only opposite channel states count as fault
package inhibit_mon_pkg;

  // Clock rate
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;

  // Input timing in milliseconds
  localparam int unsigned PULSE_IGNORE_MS = 2;     // Longest ignored test pulse
  localparam int unsigned LOW_REACT_MS    = 6;     // Low level accepted after this
  localparam int unsigned TOLERATE_MS     = 1600;  // Disagreement always tolerated
  localparam int unsigned FAULT_MAX_MS    = 3000;  // Disagreement always faulted
  localparam int unsigned FAULT_TYP_MS    = 2300;  // Chosen trip point in between

  // Derived cycle counts
  localparam int unsigned LOW_REACT_CYC   = LOW_REACT_MS * CYC_PER_MS;
  localparam int unsigned FAULT_CYC       = FAULT_TYP_MS * CYC_PER_MS;
  localparam int unsigned TIMER_W         = 32;

  // Avalon register byte offsets
  localparam logic [3:0] CTRL_OFS   = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] HIST_OFS   = 4'h8;

  // Control register bits
  localparam int unsigned CTRL_RUN_EN_BIT = 0;  // Software run permission
  localparam int unsigned CTRL_START_BIT  = 1;  // Write 1: start attempt
  localparam int unsigned CTRL_STOP_BIT   = 2;  // Write 1: stop request

  // Status register bits
  localparam int unsigned STAT_TRIP_BIT   = 6;  // Sticky trip, write 1 clears

  // Reset values
  localparam logic        RUN_EN_RST = 1'b0;
  localparam logic [15:0] HIST_RST   = 16'h0000;
  localparam logic [31:0] ZERO_WORD  = 32'h0000_0000;

  // Monitor states
  typedef enum logic [1:0] {
    ST_SAFE,
    ST_ENABLED,
    ST_MISMATCH,
    ST_FAULT
  } mon_state_t;

  // Drive control command strobes
  typedef struct packed {
    logic start;  // Start attempt pulse
    logic stop;   // Stop request pulse
  } drive_cmd_t;

  // Status register layout, low byte
  typedef struct packed {
    logic       safe_on;   // Bit 7
    logic       trip;      // Bit 6
    logic       running;   // Bit 5
    logic       fault;     // Bit 4
    logic       filt_b;    // Bit 3
    logic       filt_a;    // Bit 2
    mon_state_t state;     // Bits 1:0
  } status_t;

endpackage : inhibit_mon_pkg

// ===== design/torque_inhibit_monitor.sv
// Dual-channel torque inhibit monitor with Avalon-MM register access
`timescale 1ns/1ps

module torque_inhibit_monitor #(
  parameter int unsigned LOW_REACT_CYC = inhibit_mon_pkg::LOW_REACT_CYC,  // Low filter length
  parameter int unsigned FAULT_CYC     = inhibit_mon_pkg::FAULT_CYC       // Mismatch limit
) (
  input  wire logic                        clk_i,
  input  wire logic                        rst_n_i,
  // Safety channel inputs
  input  wire logic                        inhibit_channel_a_in_i,
  input  wire logic                        inhibit_channel_b_in_i,
  // Drive control side
  input  wire inhibit_mon_pkg::drive_cmd_t drive_cmd_i,
  input  wire logic                        internal_fault_i,
  output logic                             drive_enable_o,
  output logic                             safe_state_status_o,
  output logic                             inhibit_trip_o,
  output logic                             trip_history_o,
  // Avalon-MM slave
  input  wire logic [3:0]                  address_i,
  input  wire logic                        read_i,
  input  wire logic                        write_i,
  input  wire logic [31:0]                 writedata_i,
  input  wire logic [3:0]                  byteenable_i,
  output logic [31:0]                      readdata_o,
  output logic                             waitrequest_o
);

  // Raw channel inputs as a vector
  logic [1:0] raw_in;
  // Filtered channel levels, high means released
  logic [1:0] filt_q;

  assign raw_in = {inhibit_channel_b_in_i, inhibit_channel_a_in_i};

  // Per-channel synchroniser and low-level filter
  generate
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
      logic        meta_q;   // First stage, read only by the second
      logic        sync_q;   // Synchronised level
      logic [31:0] low_q;    // Cycles spent low
      logic        low_done;

      assign low_done = (low_q >= 32'(LOW_REACT_CYC) - 32'h1);

      // Two-stage synchroniser
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else begin
          meta_q <= raw_in[ch];
          sync_q <= meta_q;
        end
      end

      // Low must persist before it is believed; highs pass at once
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          low_q       <= 32'h0;
          filt_q[ch]  <= 1'b0;
        end else if (sync_q) begin
          low_q       <= 32'h0;
          filt_q[ch]  <= 1'b1;
        end else if (low_done) begin
          filt_q[ch]  <= 1'b0;
        end else begin
          low_q       <= low_q + 32'h1;
        end
      end
    end
  endgenerate

  // Channel agreement decode
  logic both_high;
  logic both_low;
  logic disagree;

  assign both_high = filt_q[0] & filt_q[1];
  assign both_low  = ~filt_q[0] & ~filt_q[1];
  assign disagree  = filt_q[0] ^ filt_q[1];

  // Disagreement timer and fault latch
  logic [31:0] mis_q;
  logic        fault_q;
  logic        mis_limit;

  assign mis_limit = disagree & (mis_q >= 32'(FAULT_CYC) - 32'h1);

  // Timer runs only while channels oppose each other
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mis_q <= 32'h0;
    end else if (!disagree) begin
      mis_q <= 32'h0;
    end else if (!mis_limit) begin
      mis_q <= mis_q + 32'h1;
    end
  end

  // Fault latch; only a reset (power cycle) releases it
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      fault_q <= 1'b0;
    end else if (mis_limit) begin
      fault_q <= 1'b1;
    end
  end

  // Monitor state
  inhibit_mon_pkg::mon_state_t state_d;
  inhibit_mon_pkg::mon_state_t state_q;

  // Next state from fault latch and channel levels
  always_comb begin
    state_d = inhibit_mon_pkg::ST_SAFE;
    case (1'b1)
      fault_q:   state_d = inhibit_mon_pkg::ST_FAULT;
      both_high: state_d = inhibit_mon_pkg::ST_ENABLED;
      both_low:  state_d = inhibit_mon_pkg::ST_SAFE;
      disagree:  state_d = inhibit_mon_pkg::ST_MISMATCH;
      default:   state_d = inhibit_mon_pkg::ST_SAFE;
    endcase
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q <= inhibit_mon_pkg::ST_SAFE;
    end else begin
      state_q <= state_d;
    end
  end

  // Drive permission and inhibit decode
  logic permit;
  logic inhibited;

  assign permit    = (state_q == inhibit_mon_pkg::ST_ENABLED);
  assign inhibited = ~permit;

  // Register bus decode
  logic        bus_req;
  logic        ack_q;
  logic        wr_take;
  logic        sel_ctrl;
  logic        sel_status;
  logic        sel_hist;

  assign bus_req       = read_i | write_i;
  assign waitrequest_o = bus_req & ~ack_q;
  assign wr_take       = write_i & ack_q;
  assign sel_ctrl      = (address_i == inhibit_mon_pkg::CTRL_OFS);
  assign sel_status    = (address_i == inhibit_mon_pkg::STATUS_OFS);
  assign sel_hist      = (address_i == inhibit_mon_pkg::HIST_OFS);

  // Software command decode, low byte lane only
  logic ctrl_wr;
  logic sw_start;
  logic sw_stop;
  logic trip_clr;

  assign ctrl_wr  = wr_take & sel_ctrl & byteenable_i[0];
  assign sw_start = ctrl_wr & writedata_i[inhibit_mon_pkg::CTRL_START_BIT];
  assign sw_stop  = ctrl_wr & writedata_i[inhibit_mon_pkg::CTRL_STOP_BIT];
  assign trip_clr = wr_take & sel_status & byteenable_i[0]
                  & writedata_i[inhibit_mon_pkg::STAT_TRIP_BIT];

  // Software run enable bit
  logic run_en_q;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      run_en_q <= inhibit_mon_pkg::RUN_EN_RST;
    end else if (ctrl_wr) begin
      run_en_q <= writedata_i[inhibit_mon_pkg::CTRL_RUN_EN_BIT];
    end
  end

  // Start and stop attempts from hardware or software
  logic start_try;
  logic stop_req;
  logic running_q;

  assign start_try = drive_cmd_i.start | sw_start;
  assign stop_req  = drive_cmd_i.stop | sw_stop;

  // Drive run state; inhibition drops it at once
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      running_q <= 1'b0;
    end else if (inhibited | stop_req | ~run_en_q) begin
      running_q <= 1'b0;
    end else if (start_try) begin
      running_q <= 1'b1;
    end
  end

  // Trip and history events
  logic inhib_event;
  logic trip_set;

  assign inhib_event = inhibited & (start_try | running_q);
  assign trip_set    = inhib_event | internal_fault_i;

  // Trip flag, trip history pulse and entry count
  logic        trip_q;
  logic        hist_q;
  logic [15:0] hist_cnt_q;

  // A new trip wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      trip_q <= 1'b0;
    end else if (trip_set) begin
      trip_q <= 1'b1;
    end else if (trip_clr) begin
      trip_q <= 1'b0;
    end
  end

  // History entry only for inhibition at start or while running
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      hist_q     <= 1'b0;
      hist_cnt_q <= inhibit_mon_pkg::HIST_RST;
    end else begin
      hist_q <= inhib_event;
      if (inhib_event) begin
        hist_cnt_q <= hist_cnt_q + 16'h1;
      end
    end
  end

  // Status word assembly
  inhibit_mon_pkg::status_t status;

  assign status.safe_on = (state_q == inhibit_mon_pkg::ST_SAFE);
  assign status.trip    = trip_q;
  assign status.running = running_q;
  assign status.fault   = fault_q;
  assign status.filt_b  = filt_q[1];
  assign status.filt_a  = filt_q[0];
  assign status.state   = state_q;

  // Read multiplexer; unmapped addresses read zero
  logic [31:0] rd_mux;

  assign rd_mux = sel_ctrl   ? {31'h0, run_en_q}
                : sel_status ? {24'h0, status}
                : sel_hist   ? {16'h0, hist_cnt_q}
                : inhibit_mon_pkg::ZERO_WORD;

  // Bus answer: one wait cycle, data valid at the releasing edge
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ack_q      <= 1'b0;
      readdata_o <= inhibit_mon_pkg::ZERO_WORD;
    end else begin
      ack_q <= bus_req & ~ack_q;
      if (read_i & ~ack_q) begin
        readdata_o <= rd_mux;
      end
    end
  end

  // Outputs
  assign drive_enable_o      = running_q;
  assign safe_state_status_o = status.safe_on;
  assign inhibit_trip_o      = trip_q;
  assign trip_history_o      = hist_q;

endmodule : torque_inhibit_monitor

// ===== tb/inhibit_mon_checker_assertions.sv
// Port checker for the torque inhibit monitor
`timescale 1ns/1ps
module inhibit_mon_checker #(
  parameter int unsigned LOW_REACT_CYC = 20,
  parameter int unsigned FAULT_CYC     = 200
) (
  input wire logic                        clk_i,
  input wire logic                        rst_n_i,
  input wire logic                        inhibit_channel_a_in_i,
  input wire logic                        inhibit_channel_b_in_i,
  input wire inhibit_mon_pkg::drive_cmd_t drive_cmd_i,
  input wire logic                        internal_fault_i,
  input wire logic                        drive_enable_o,
  input wire logic                        safe_state_status_o,
  input wire logic                        inhibit_trip_o,
  input wire logic                        trip_history_o
);
  wire logic        ca = inhibit_channel_a_in_i;  // Raw channel A
  wire logic        cb = inhibit_channel_b_in_i;  // Raw channel B
  logic      [15:0] dif_q, low_q, hi_q;           // Run lengths of input patterns
  logic             flt_q;                        // Disagreement long past the limit
  // Count unbroken runs of each input pattern
  always_ff @(posedge clk_i) begin
    dif_q <= (rst_n_i && ca != cb) ? dif_q + 16'h1 : 16'h0;
    low_q <= (rst_n_i && !ca && !cb) ? low_q + 16'h1 : 16'h0;
    hi_q  <= (rst_n_i && ca && cb) ? hi_q + 16'h1 : 16'h0;
    flt_q <= rst_n_i && (flt_q || dif_q > 16'(FAULT_CYC + LOW_REACT_CYC + 10));
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Inhibited start: trip set and a one-cycle history pulse
  sequence s_entry;
    inhibit_trip_o && trip_history_o ##1 !trip_history_o;
  endsequence
  chk_safe_blocks_run: assert property (safe_state_status_o |-> !drive_enable_o)
    else $error("safe state with drive enabled");
  chk_both_low_safe: assert property (
    low_q > 16'(LOW_REACT_CYC + 8) && !flt_q |-> safe_state_status_o)
    else $error("both inputs low but status off");
  chk_both_high_off: assert property (hi_q > 16'h8 |-> !safe_state_status_o)
    else $error("both inputs high but status on");
  chk_mismatch_blocks: assert property (
    dif_q > 16'(LOW_REACT_CYC + 8) |-> !safe_state_status_o && !drive_enable_o)
    else $error("disagreement without blocking");
  chk_fault_latched: assert property (flt_q |-> !safe_state_status_o && !drive_enable_o)
    else $error("latched fault left");
  chk_start_trip: assert property (drive_cmd_i.start && safe_state_status_o |=> s_entry)
    else $error("inhibited start without trip entry");
  chk_entry_cause: assert property (
    trip_history_o |-> $past(drive_cmd_i.start) || $past(drive_enable_o))
    else $error("history entry while stopped");
  chk_internal_trip: assert property (internal_fault_i |=> inhibit_trip_o)
    else $error("internal fault without trip");
endmodule // inhibit_mon_checker

// ===== tb/relay_pair_model.sv
// Model of the external safety relay pair driving both inhibit inputs
`timescale 1ns/1ps
module relay_pair_model (
  input  wire logic       clk_i,
  input  wire logic       lvl_a_i,    // Wanted level of channel A
  input  wire logic       lvl_b_i,    // Wanted level of channel B
  input  wire logic [3:0] skew_i,     // Channel B trails A by this many cycles plus one
  input  wire logic [7:0] pulse_a_i,  // Test pulse width on A, zero for none
  input  wire logic [7:0] pulse_b_i,  // Test pulse width on B, zero for none
  output logic            ch_a_o,
  output logic            ch_b_o
);
  logic [15:0] hist_q = '0;  // Past wanted levels of channel B
  logic [7:0]  pa_q   = '0;  // Low cycles left on A
  logic [7:0]  pb_q   = '0;  // Low cycles left on B
  // Relays switch together apart from a small skew, test pulses stay short
  always_ff @(posedge clk_i) begin
    hist_q <= {hist_q[14:0], lvl_b_i};
    pa_q   <= (pulse_a_i != 8'h0) ? pulse_a_i : pa_q - 8'(pa_q != 8'h0);
    pb_q   <= (pulse_b_i != 8'h0) ? pulse_b_i : pb_q - 8'(pb_q != 8'h0);
  end
  assign ch_a_o = lvl_a_i && (pa_q == 8'h0);
  assign ch_b_o = hist_q[skew_i] && (pb_q == 8'h0);
endmodule // relay_pair_model

// ===== tb/test_dual_channel_torque_inhibit_monitor.sv
// Self-checking bench for the torque inhibit monitor
`timescale 1ns/1ps
module test_dual_channel_torque_inhibit_monitor;
  localparam int unsigned LRC = 20;   // Short low filter
  localparam int unsigned FC  = 200;  // Short mismatch limit
  // Longest test pulse, kept under the ignored width scaled to the short filter
  localparam int unsigned PW  = LRC * inhibit_mon_pkg::PULSE_IGNORE_MS
                                / inhibit_mon_pkg::LOW_REACT_MS;
  logic clk_i, rst_n_i, la, lb, ca, cb, ifl, rd, wr, en, safe, trip, hist, wreq;
  logic [3:0]  skew, addr;
  logic [7:0]  pa, pb;
  logic [31:0] wdata, rdata, rd_q;
  logic [32:0] e, g, exp_q[$];  // Notes; bit 32 marks a read
  inhibit_mon_pkg::drive_cmd_t cmd;
  int error_cnt, check_count;
  relay_pair_model far (.clk_i(clk_i), .lvl_a_i(la), .lvl_b_i(lb), .skew_i(skew),
    .pulse_a_i(pa), .pulse_b_i(pb), .ch_a_o(ca), .ch_b_o(cb));
  torque_inhibit_monitor #(.LOW_REACT_CYC(LRC), .FAULT_CYC(FC)) dut (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .inhibit_channel_a_in_i(ca), .inhibit_channel_b_in_i(cb),
    .drive_cmd_i(cmd), .internal_fault_i(ifl), .drive_enable_o(en),
    .safe_state_status_o(safe), .inhibit_trip_o(trip), .trip_history_o(hist),
    .address_i(addr), .read_i(rd), .write_i(wr), .writedata_i(wdata),
    .byteenable_i(4'hF), .readdata_o(rdata), .waitrequest_o(wreq));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Note {enable, safe, trip, history} for the monitor
  task automatic want(input logic [3:0] v);
    exp_q.push_back({29'h0, v});
  endtask
  // Avalon request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    do @(posedge clk_i); while (wreq !== 1'b0);  // Waitrequest seen low at this edge
    rd_q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    cyc(1);
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0);
    exp_q.push_back({1'b1, x});
  endtask
  task automatic start;
    cmd <= 2'h2;
    cyc(1);
    cmd <= 2'h0;
  endtask
  // Compare each note with what the design shows
  always @(negedge clk_i) begin
    while (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      g = e[32] ? {1'b1, rd_q} : {29'h0, en, safe, trip, hist};
      check_count++;
      if (g !== e) begin
        error_cnt++;
        $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
      end
    end
  end
  task automatic print_verdict;
    $display("Checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    cyc(5000);
    error_cnt++;
    print_verdict();
  end
  initial begin
    {rst_n_i, la, lb, skew, pa, pb, cmd, ifl, rd, wr, addr, wdata} = '0;
    error_cnt = 0;
    check_count = 0;
    void'($urandom(32'hBC01B184));
    cyc(2);
    rst_n_i <= 1'b1;
    cyc(2);
    want(4'h4);
    rchk(4'h4, 32'h80);
    rchk(4'hC, 32'h0);
    start();
    want(4'h7);
    cyc(1);
    want(4'h6);
    rchk(4'h8, 32'h1);
    bus(1'b1, 4'h4, 32'h40);
    ifl <= 1'b1;
    cyc(1);
    ifl <= 1'b0;
    want(4'h6);
    bus(1'b1, 4'h4, 32'h40);
    $display("test trips done");
    skew <= 4'($urandom_range(0, 8));
    la <= 1'b1;
    lb <= 1'b1;
    cyc(20);
    want(4'h0);
    bus(1'b1, 4'h0, 32'h1);
    rchk(4'h0, 32'h1);
    start();
    want(4'h8);
    cmd <= 2'h1;
    cyc(1);
    cmd <= 2'h0;
    cyc(1);
    want(4'h0);
    bus(1'b1, 4'h0, 32'h3);
    want(4'h8);
    for (int i = 0; i < 4; i++) begin
      pa <= 8'($urandom_range(1, PW));
      pb <= 8'($urandom_range(1, PW));
      cyc(1);
      pa <= 8'h0;
      pb <= 8'h0;
      cyc(LRC + 4);
      want(4'h8);
    end
    la <= 1'b0;
    cyc(LRC - 1);
    want(4'h8);
    cyc(8);
    want(4'h2);
    rchk(4'h8, 32'h2);
    $display("test running done");
    cyc(110);
    la <= 1'b1;
    cyc(10);
    la <= 1'b0;
    cyc(LRC + 110);
    rchk(4'h4, 32'h4A);
    lb <= 1'b0;
    cyc(LRC + 20);
    want(4'h6);
    $display("test tolerance done");
    la <= 1'b1;
    cyc(FC + LRC + 60);
    want(4'h2);
    rchk(4'h4, 32'h57);
    lb <= 1'b1;
    cyc(20);
    start();
    want(4'h3);
    la <= 1'b0;
    lb <= 1'b0;
    cyc(LRC + 20);
    want(4'h2);
    rst_n_i <= 1'b0;
    cyc(2);
    rst_n_i <= 1'b1;
    cyc(2);
    want(4'h4);
    cyc(2);
    $display("test fault done");
    print_verdict();
  end
endmodule // test_dual_channel_torque_inhibit_monitor
bind torque_inhibit_monitor inhibit_mon_checker #(.LOW_REACT_CYC(LOW_REACT_CYC),
  .FAULT_CYC(FAULT_CYC)) chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .inhibit_channel_a_in_i(inhibit_channel_a_in_i),
  .inhibit_channel_b_in_i(inhibit_channel_b_in_i), .drive_cmd_i(drive_cmd_i),
  .internal_fault_i(internal_fault_i), .drive_enable_o(drive_enable_o),
  .safe_state_status_o(safe_state_status_o), .inhibit_trip_o(inhibit_trip_o),
  .trip_history_o(trip_history_o));
